// ==== logic/operand_pkg.sv ====
/*
   Constants, enumerations and decode types for the operand addressing block.
   Assumes a 16-bit data space addressed in bytes, with sixteen word-wide working registers.
*/
package operand_pkg;

   localparam logic [15:0] near_top_addr  = 16'h1fff;
   localparam logic [15:0] xfer_top_addr  = 16'hfffe;
   localparam logic [15:0] default_work_reg_top_addr  = 16'h001f;
   localparam logic [3:0]  default_reg    = 4'h0;
   localparam int          default_work_reg_count     = 16;
   localparam logic [15:0] default_work_reg_reset_val = 16'h0000;
   localparam logic [15:0] data_reset_val = 16'h0000;
   localparam logic [7:0]  byte_fill      = 8'h00;

   typedef enum logic [1:0] {
      mode_file,
      mode_direct,
      mode_indirect,
      mode_immediate
   } addr_mode_t;

   typedef enum logic [1:0] {
      kind_alu,
      kind_load,
      kind_store,
      kind_loop_count
   } op_kind_t;

   typedef enum logic [1:0] {
      st_idle,
      st_mem,
      st_exec
   } state_t;

endpackage : operand_pkg

// ==== logic/default_work_reg_port_if.sv ====
/*
   Port bundle between the operand addressing control and the working register array.
   Assumes one writer (the control) and combinational read ports on the array.
*/
`timescale 1ns/1ps
`default_nettype none
interface default_work_reg_port_if;
   logic [3:0]  rd_sel_a;
   logic [15:0] rd_data_a;
   logic [3:0]  rd_sel_b;
   logic [15:0] rd_data_b;
   logic [15:0] rd_data_w0;
   logic        wr_en;
   logic [3:0]  wr_sel;
   logic [1:0]  wr_lanes;
   logic [15:0] wr_data;

   modport array (input rd_sel_a, rd_sel_b, wr_en, wr_sel, wr_lanes, wr_data,
                  output rd_data_a, rd_data_b, rd_data_w0);
   modport user  (output rd_sel_a, rd_sel_b, wr_en, wr_sel, wr_lanes, wr_data,
                  input rd_data_a, rd_data_b, rd_data_w0);
endinterface : default_work_reg_port_if
`default_nettype wire

// ==== logic/work_reg_array.sv ====
/*
   Working register array: sixteen 16-bit flip-flop registers, three read ports (two selectable, one fixed on register 0), one write port.
   Assumes writes arrive with a byte-lane mask from the addressing control.
*/
`timescale 1ns/1ps
`default_nettype none
module work_reg_array (
   input  wire logic   mclk,
   input  wire logic   rst_n,
   default_work_reg_port_if.array  wp
);

   typedef struct packed {
      logic [operand_pkg::default_work_reg_count-1:0][15:0] regs;
   } array_state_t;

   array_state_t s_q;
   array_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (wp.wr_en) begin
         if (wp.wr_lanes[0]) begin
            s_d.regs[wp.wr_sel][7:0] = wp.wr_data[7:0];
         end
         if (wp.wr_lanes[1]) begin
            s_d.regs[wp.wr_sel][15:8] = wp.wr_data[15:8];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q.regs <= {operand_pkg::default_work_reg_count{operand_pkg::default_work_reg_reset_val}};
      end else begin
         s_q <= s_d;
      end
   end

   assign wp.rd_data_a  = s_q.regs[wp.rd_sel_a];
   assign wp.rd_data_b  = s_q.regs[wp.rd_sel_b];
   assign wp.rd_data_w0 = s_q.regs[operand_pkg::default_reg];

endmodule : work_reg_array
`default_nettype wire

// ==== logic/data_operand_addressing.sv ====
/*
   Operand addressing control: resolves file-register, direct, indirect and immediate
   operands, issues data memory accesses and steers results back to memory or registers.
   Assumes the decoder presents one request at a time while req_ready is high, memory takes
   a strobe in the cycle it is shown and later answers a read with mem_rvalid, and the
   execution unit answers each exec strobe with result_valid.
*/
`timescale 1ns/1ps
`default_nettype none
module data_operand_addressing (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [1:0]  req_mode,
   input  wire logic [1:0]  req_kind,
   input  wire logic        req_byte,
   input  wire logic        req_default_work_reg_dest,
   input  wire logic [15:0] req_file_addr,
   input  wire logic [3:0]  req_reg_sel,
   input  wire logic [3:0]  req_dst_sel,
   input  wire logic [15:0] req_literal,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic             mem_byte,
   output logic [15:0]      mem_addr,
   output logic [15:0]      mem_wdata,
   input  wire logic        mem_rvalid,
   input  wire logic [15:0] mem_rdata,
   output logic             exec,
   output logic [15:0]      operand_a,
   output logic [15:0]      operand_b,
   input  wire logic        result_valid,
   input  wire logic [15:0] result_data,
   output logic [15:0]      loop_count,
   output logic             loop_count_valid,
   output logic             done,
   output logic             addr_fault
);

   typedef struct packed {
      operand_pkg::state_t   st;
      operand_pkg::op_kind_t kind;
      logic                  byte_op;
      logic                  to_reg;
      logic [3:0]            tgt_sel;
      logic                  tgt_hi;
      logic [15:0]           ea;
      logic                  mem_rd;
      logic                  mem_wr;
      logic                  mem_byte;
      logic [15:0]           mem_addr;
      logic [15:0]           mem_wdata;
      logic                  exec;
      logic [15:0]           opa;
      logic [15:0]           opb;
      logic [15:0]           loop_cnt;
      logic                  loop_valid;
      logic                  done;
      logic                  fault;
   } ctrl_state_t;

   ctrl_state_t s_q;
   ctrl_state_t s_d;

   default_work_reg_port_if wp ();

   work_reg_array u_regs (
      .mclk  (mclk),
      .rst_n (rst_n),
      .wp    (wp.array)
   );

   // byte operands are zero-extended; a byte inside a mapped register picks its lane
   function automatic logic [15:0] lane_pick(input logic [15:0] w, input logic is_byte,
                                             input logic hi);
      logic [15:0] r;
      r = w;
      if (is_byte) begin
         r = hi ? {operand_pkg::byte_fill, w[15:8]} : {operand_pkg::byte_fill, w[7:0]};
      end
      return r;
   endfunction : lane_pick

   logic [15:0] acc_addr;
   logic        mapped;
   logic        eff_byte;
   logic [15:0] wr_word;

   always_comb begin
      s_d            = s_q;
      s_d.mem_rd     = 1'b0;
      s_d.mem_wr     = 1'b0;
      s_d.exec       = 1'b0;
      s_d.loop_valid = 1'b0;
      s_d.done       = 1'b0;
      s_d.fault      = 1'b0;
      wp.rd_sel_a    = req_reg_sel;
      wp.wr_en       = 1'b0;
      wp.wr_sel      = s_q.tgt_sel;
      wp.wr_lanes    = 2'b11;
      wp.wr_data     = result_data;
      wr_word        = result_data;
      // the transfer always moves whole words
      eff_byte = req_byte && (req_kind == operand_pkg::kind_alu);
      if (req_mode == operand_pkg::mode_indirect) begin
         acc_addr = wp.rd_data_a;
      end else begin
         acc_addr = req_file_addr;
      end
      // low addresses alias the register array instead of reaching memory
      mapped      = (acc_addr <= operand_pkg::default_work_reg_top_addr);
      wp.rd_sel_b = acc_addr[4:1];

      case (s_q.st)
         operand_pkg::st_idle: begin
            if (req_valid) begin
               s_d.kind    = operand_pkg::op_kind_t'(req_kind);
               s_d.byte_op = eff_byte;
               s_d.ea      = acc_addr;
               s_d.tgt_hi  = 1'b0;
               case (operand_pkg::addr_mode_t'(req_mode))
                  operand_pkg::mode_immediate: begin
                     if (req_kind != operand_pkg::kind_alu) begin
                        s_d.fault = 1'b1;
                        s_d.done  = 1'b1;
                     end else begin
                        // constant straight from the instruction, memory stays idle
                        s_d.opa     = req_literal;
                        s_d.opb     = lane_pick(wp.rd_data_a, eff_byte, 1'b0);
                        s_d.to_reg  = 1'b1;
                        s_d.tgt_sel = req_dst_sel;
                        s_d.exec    = 1'b1;
                        s_d.st      = operand_pkg::st_exec;
                     end
                  end
                  operand_pkg::mode_direct: begin
                     if (req_kind == operand_pkg::kind_loop_count) begin
                        s_d.loop_cnt   = wp.rd_data_a;
                        s_d.loop_valid = 1'b1;
                        s_d.done       = 1'b1;
                     end else if (req_kind != operand_pkg::kind_alu) begin
                        s_d.fault = 1'b1;
                        s_d.done  = 1'b1;
                     end else begin
                        s_d.opa     = lane_pick(wp.rd_data_a, eff_byte, 1'b0);
                        s_d.opb     = wp.rd_data_w0;
                        s_d.to_reg  = 1'b1;
                        s_d.tgt_sel = req_dst_sel;
                        s_d.exec    = 1'b1;
                        s_d.st      = operand_pkg::st_exec;
                     end
                  end
                  default: begin
                     if (req_kind == operand_pkg::kind_loop_count ||
                         (req_mode == operand_pkg::mode_indirect &&
                          req_kind != operand_pkg::kind_alu)) begin
                        s_d.fault = 1'b1;
                        s_d.done  = 1'b1;
                     end else if (req_mode == operand_pkg::mode_file &&
                                  req_kind == operand_pkg::kind_alu &&
                                  acc_addr > operand_pkg::near_top_addr) begin
                        s_d.fault = 1'b1;
                        s_d.done  = 1'b1;
                     end else if (req_kind != operand_pkg::kind_alu &&
                                  (acc_addr > operand_pkg::xfer_top_addr || acc_addr[0])) begin
                        s_d.fault = 1'b1;
                        s_d.done  = 1'b1;
                     end else if (req_kind == operand_pkg::kind_store) begin
                        if (mapped) begin
                           wp.wr_en    = 1'b1;
                           wp.wr_sel   = acc_addr[4:1];
                           wp.wr_data  = wp.rd_data_a;
                        end else begin
                           s_d.mem_wr    = 1'b1;
                           s_d.mem_byte  = 1'b0;
                           s_d.mem_addr  = acc_addr;
                           s_d.mem_wdata = wp.rd_data_a;
                        end
                        s_d.done = 1'b1;
                     end else begin
                        if (req_kind == operand_pkg::kind_load) begin
                           s_d.to_reg  = 1'b1;
                           s_d.tgt_sel = req_dst_sel;
                        end else if (req_mode == operand_pkg::mode_file && req_default_work_reg_dest) begin
                           s_d.to_reg  = 1'b1;
                           s_d.tgt_sel = operand_pkg::default_reg;
                        end else begin
                           // read-modify-write lands back where the operand came from
                           s_d.to_reg  = mapped;
                           s_d.tgt_sel = acc_addr[4:1];
                           s_d.tgt_hi  = acc_addr[0];
                        end
                        if (mapped && req_kind == operand_pkg::kind_load) begin
                           wp.wr_en   = 1'b1;
                           wp.wr_sel  = req_dst_sel;
                           wp.wr_data = wp.rd_data_b;
                           s_d.done   = 1'b1;
                        end else if (mapped) begin
                           s_d.opa  = lane_pick(wp.rd_data_b, eff_byte, acc_addr[0]);
                           s_d.opb  = wp.rd_data_w0;
                           s_d.exec = 1'b1;
                           s_d.st   = operand_pkg::st_exec;
                        end else begin
                           s_d.mem_rd   = 1'b1;
                           s_d.mem_byte = eff_byte;
                           s_d.mem_addr = acc_addr;
                           s_d.st       = operand_pkg::st_mem;
                        end
                     end
                  end
               endcase
            end
         end
         operand_pkg::st_mem: begin
            if (mem_rvalid) begin
               if (s_q.kind == operand_pkg::kind_load) begin
                  wp.wr_en   = 1'b1;
                  wp.wr_data = mem_rdata;
                  s_d.done   = 1'b1;
                  s_d.st     = operand_pkg::st_idle;
               end else begin
                  s_d.opa  = lane_pick(mem_rdata, s_q.byte_op, 1'b0);
                  s_d.opb  = wp.rd_data_w0;
                  s_d.exec = 1'b1;
                  s_d.st   = operand_pkg::st_exec;
               end
            end
         end
         operand_pkg::st_exec: begin
            if (result_valid) begin
               if (s_q.to_reg) begin
                  // a byte result only touches one lane: the one a read-modify-write took it from, else the low lane
                  wr_word    = {result_data[7:0], result_data[7:0]};
                  wp.wr_en   = 1'b1;
                  wp.wr_data = s_q.byte_op ? wr_word : result_data;
                  wp.wr_lanes = !s_q.byte_op ? 2'b11 : (s_q.tgt_hi ? 2'b10 : 2'b01);
               end else begin
                  s_d.mem_wr    = 1'b1;
                  s_d.mem_byte  = s_q.byte_op;
                  s_d.mem_addr  = s_q.ea;
                  s_d.mem_wdata = result_data;
               end
               s_d.done = 1'b1;
               s_d.st   = operand_pkg::st_idle;
            end
         end
         default: begin
            s_d.st = operand_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q    <= '0;
         s_q.st <= operand_pkg::st_idle;
      end else begin
         s_q <= s_d;
      end
   end

   assign req_ready        = (s_q.st == operand_pkg::st_idle);
   assign mem_rd           = s_q.mem_rd;
   assign mem_wr           = s_q.mem_wr;
   assign mem_byte         = s_q.mem_byte;
   assign mem_addr         = s_q.mem_addr;
   assign mem_wdata        = s_q.mem_wdata;
   assign exec             = s_q.exec;
   assign operand_a        = s_q.opa;
   assign operand_b        = s_q.opb;
   assign loop_count       = s_q.loop_cnt;
   assign loop_count_valid = s_q.loop_valid;
   assign done             = s_q.done;
   assign addr_fault       = s_q.fault;

endmodule : data_operand_addressing
`default_nettype wire

// ==== verification/data_operand_addressing_asserts.sv ====
/*
   port checker for the operand addressing control
   assumes the driver holds req_valid low while reset is held
*/
`timescale 1ns/1ps
`default_nettype none
module data_operand_addressing_asserts (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [1:0]  req_mode,
   input wire logic [1:0]  req_kind,
   input wire logic        req_byte,
   input wire logic        req_default_work_reg_dest,
   input wire logic [15:0] req_file_addr,
   input wire logic [15:0] req_literal,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic        mem_byte,
   input wire logic [15:0] mem_addr,
   input wire logic        exec,
   input wire logic [15:0] operand_a,
   input wire logic        result_valid,
   input wire logic        loop_count_valid,
   input wire logic        done,
   input wire logic        addr_fault
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic        tk;
   logic        fa;
   logic        fm;
   logic        rmw_q;
   logic        keep_q;
   logic [15:0] fa_q;
   assign tk = req_valid && req_ready;
   assign fa = tk && req_mode == operand_pkg::mode_file && req_kind == operand_pkg::kind_alu;
   assign fm = tk && req_mode == operand_pkg::mode_file && !req_file_addr[0]
               && req_file_addr > 16'h001f;
   // steering is only visible at the take, so it is held until done
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rmw_q  <= 1'b0;
         keep_q <= 1'b0;
         fa_q   <= 16'h0000;
      end else if (fa) begin
         rmw_q  <= !req_default_work_reg_dest && req_file_addr inside {[16'h0020:16'h1fff]};
         keep_q <= req_default_work_reg_dest && req_file_addr <= 16'h1fff;
         fa_q   <= req_file_addr;
      end else if (done) begin
         rmw_q  <= 1'b0;
         keep_q <= 1'b0;
      end
   end
   property p_near; fa && req_file_addr > 16'h1fff |=> addr_fault && done && !mem_rd; endproperty
   a_near: assert property (p_near) else $error("near limit not kept");
   property p_xfer; fm && req_kind == operand_pkg::kind_load
      |=> mem_rd && !mem_byte && mem_addr == $past(req_file_addr); endproperty
   a_xfer: assert property (p_xfer) else $error("transfer read wrong");
   property p_byte; fa && req_byte && req_file_addr inside {[16'h0020:16'h1fff]}
      |=> mem_rd && mem_byte; endproperty
   a_byte: assert property (p_byte) else $error("byte access missing");
   property p_store; fm && req_kind == operand_pkg::kind_store
      |=> mem_wr && done && mem_addr == $past(req_file_addr); endproperty
   a_store: assert property (p_store) else $error("store write wrong");
   property p_rmw; result_valid && rmw_q |=> mem_wr && done && mem_addr == fa_q; endproperty
   a_rmw: assert property (p_rmw) else $error("write back missing");
   property p_keep; result_valid && keep_q |=> done && !mem_wr; endproperty
   a_keep: assert property (p_keep) else $error("memory written");
   property p_map; fa && req_file_addr <= 16'h001f |=> exec && !mem_rd; endproperty
   a_map: assert property (p_map) else $error("mapped register reached memory");
   property p_imm; tk && req_mode == operand_pkg::mode_immediate
      && req_kind == operand_pkg::kind_alu |=> exec && !mem_rd && operand_a == $past(req_literal);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate operand wrong");
   property p_loop; tk && req_kind == operand_pkg::kind_loop_count |=> done
      && (loop_count_valid == ($past(req_mode) == operand_pkg::mode_direct)); endproperty
   a_loop: assert property (p_loop) else $error("loop count handling wrong");
endmodule : data_operand_addressing_asserts
bind data_operand_addressing data_operand_addressing_asserts u_chk (.mclk, .rst_n,
   .req_valid, .req_ready, .req_mode, .req_kind, .req_byte, .req_default_work_reg_dest, .req_file_addr,
   .req_literal, .mem_rd, .mem_wr, .mem_byte, .mem_addr, .exec, .operand_a, .result_valid,
   .loop_count_valid, .done, .addr_fault);
`default_nettype wire

// ==== verification/operand_partner.sv ====
/*
   data memory and execution unit model, each answering after 1 to 3 cycles
   assumes strobes are one-cycle pulses; idle data lines toggle
*/
`timescale 1ns/1ps
`default_nettype none
module operand_partner (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic        mem_byte,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic            mem_rvalid,
   output logic [15:0]     mem_rdata,
   input wire logic        exec,
   input wire logic [15:0] operand_a,
   input wire logic [15:0] operand_b,
   output logic            result_valid,
   output logic [15:0]     result_data
);
   logic [15:0] mem [logic [14:0]];
   logic [15:0] ra;
   logic [15:0] w;
   logic [15:0] sum;
   logic        rb;
   logic        rd_go;
   logic        ex_go;
   int          rd_n;
   int          ex_n;
   int          seed = 4;
   function automatic logic [15:0] rdw(input logic [15:0] a);
      return mem.exists(a[15:1]) ? mem[a[15:1]] : ({a[15:1], 1'b0} ^ 16'h5a5a);
   endfunction : rdw
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rvalid <= 1'b0;
         result_valid <= 1'b0;
         mem_rdata <= 16'h0000;
         result_data <= 16'h0000;
         rd_n = 0;
         ex_n = 0;
         ra = 16'h0000;
      end else begin
         if (mem_wr) begin
            w = rdw(mem_addr);
            if (!mem_byte) w = mem_wdata;
            else if (mem_addr[0]) w[15:8] = mem_wdata[7:0];
            else w[7:0] = mem_wdata[7:0];
            mem[mem_addr[15:1]] = w;
         end
         if (mem_rd) begin
            ra = mem_addr;
            rb = mem_byte;
         end
         // one assignment per output and edge: the answer or the toggling idle value
         rd_go = !mem_rd && rd_n == 1;
         rd_n = mem_rd ? 1 + {$random(seed)} % 3 : (rd_n > 0 ? rd_n - 1 : 0);
         if (rd_go) w = rdw(ra);
         mem_rvalid <= rd_go;
         mem_rdata <= rd_go ? (rb ? {8'h00, ra[0] ? w[15:8] : w[7:0]} : w) : ~mem_rdata;
         if (exec) sum = operand_a + operand_b;
         ex_go = !exec && ex_n == 1;
         ex_n = exec ? 1 + {$random(seed)} % 3 : (ex_n > 0 ? ex_n - 1 : 0);
         result_valid <= ex_go;
         result_data <= ex_go ? sum : ~result_data;
      end
   end
endmodule : operand_partner
`default_nettype wire

// ==== verification/tb_data_operand_addressing.sv ====
/*
   self-checking bench: driver notes expected events in a queue, monitor compares them
   assumes the partner returns a + b and unwritten memory reads {addr, 0} ^ 5a5a
*/
`timescale 1ns/1ps
`default_nettype none
module tb_data_operand_addressing;
   localparam logic [1:0] mf = 2'h0, md = 2'h1, mi = 2'h2, mm = 2'h3;
   localparam logic [1:0] ka = 2'h0, kl = 2'h1, ks = 2'h2, kc = 2'h3;
   logic        mclk = 0, rst_n = 0, req_valid = 0, req_byte = 0, req_default_work_reg_dest = 0;
   logic [1:0]  req_mode = 0, req_kind = 0;
   logic [3:0]  req_reg_sel = 0, req_dst_sel = 0;
   logic [15:0] req_file_addr = 0, req_literal = 0, a, lit;
   logic        req_ready, mem_rd, mem_wr, mem_byte, mem_rvalid, exec, result_valid;
   logic        loop_count_valid, done, addr_fault;
   logic [15:0] mem_addr, mem_wdata, mem_rdata, operand_a, operand_b, result_data, loop_count;
   logic [15:0] w [16];
   logic [33:0] notes [$];
   logic [19:0] flt [7] = '{{mf, ka, 16'h2000}, {mf, kl, 16'h2001}, {mf, ks, 16'hffff},
                            {mf, kc, 16'h0000}, {md, ks, 16'h0000}, {mi, kl, 16'h0000},
                            {mm, ks, 16'h0000}};
   int          miscompares = 0, tests_run = 0, cyc = 0, seed = 4;
   data_operand_addressing DUT (.mclk, .rst_n, .req_valid, .req_ready, .req_mode, .req_kind,
      .req_byte, .req_default_work_reg_dest, .req_file_addr, .req_reg_sel, .req_dst_sel, .req_literal,
      .mem_rd, .mem_wr, .mem_byte, .mem_addr, .mem_wdata, .mem_rvalid, .mem_rdata, .exec,
      .operand_a, .operand_b, .result_valid, .result_data, .loop_count, .loop_count_valid,
      .done, .addr_fault);
   operand_partner u_far (.mclk, .rst_n, .mem_rd, .mem_wr, .mem_byte, .mem_addr, .mem_wdata,
      .mem_rvalid, .mem_rdata, .exec, .operand_a, .operand_b, .result_valid, .result_data);
   function automatic logic [15:0] fill(input logic [15:0] x);
      return {x[15:1], 1'b0} ^ 16'h5a5a;
   endfunction : fill
   task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic pop(input string nm, input logic [33:0] got);
      if (notes.size() == 0) chk(nm, got, ~got);
      else chk(nm, got, notes.pop_front());
   endtask : pop
   task end_sim;
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // request held until the edge that samples req_ready, then wait for done
   task automatic issue(input logic [1:0] m, input logic [1:0] k, input logic b,
                        input logic d, input logic [15:0] fa, input logic [3:0] rs,
                        input logic [3:0] ds, input logic [15:0] li);
      int n;
      n = 0;
      {req_mode, req_kind, req_byte, req_default_work_reg_dest, req_file_addr} <= {m, k, b, d, fa};
      {req_reg_sel, req_dst_sel, req_literal, req_valid} <= {rs, ds, li, 1'b1};
      @(posedge mclk);
      while (req_ready !== 1'b1) @(posedge mclk);
      req_valid <= 1'b0;
      do begin
         @(posedge mclk);
         n++;
      end while (done !== 1'b1 && n < 40);
      if (n >= 40) chk("done wait", 34'h0, 34'h1);
   endtask : issue
   task automatic ex(input logic [15:0] x, input logic [15:0] y);
      notes.push_back({2'd0, x, y});
   endtask : ex
   task automatic fin(input logic f);
      notes.push_back({2'd3, 31'h0, f});
   endtask : fin
   task automatic count(input int s);
      notes.push_back({2'd2, 16'h0, w[s]});
      fin(1'b0);
      issue(md, kc, 0, 0, 0, s[3:0], 0, 0);
   endtask : count
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   always @(posedge mclk) begin
      if (rst_n && exec === 1'b1) pop("exec", {2'd0, operand_a, operand_b});
      if (rst_n && mem_wr === 1'b1)
         pop("write", {2'd1, mem_addr, mem_byte ? {8'h00, mem_wdata[7:0]} : mem_wdata});
      if (rst_n && loop_count_valid === 1'b1) pop("loop", {2'd2, 16'h0, loop_count});
      if (rst_n && done === 1'b1) pop("done", {2'd3, 31'h0, addr_fault});
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         a = (16'($random(seed)) | 16'h2000) & 16'hfffe;
         fin(1'b0);
         issue(mf, kl, 0, 0, a, 0, i[3:0], 0);
         w[i] = fill(a);
         notes.push_back({2'd1, 11'h200, i[3:0], 1'b0, w[i]});
         fin(1'b0);
         issue(mf, ks, 0, 0, {11'h200, i[3:0], 1'b0}, i[3:0], 0, 0);
      end
      count($random(seed) & 15);
      foreach (flt[j]) begin
         fin(1'b1);
         issue(flt[j][19:18], flt[j][17:16], 0, 0, flt[j][15:0], 1, 1, 0);
      end
      fin(1'b0);
      issue(mf, kl, 0, 0, 16'hfffe, 0, 4'h3, 0);
      w[3] = 16'hfffe ^ 16'h5a5a;
      ex(w[3], w[0]);
      fin(1'b0);
      issue(mf, ka, 0, 1, 16'h0006, 0, 0, 0);
      w[0] = w[3] + w[0];
      ex(fill(16'h1000), w[0]);
      fin(1'b0);
      issue(mf, ka, 0, 1, 16'h1000, 0, 0, 0);
      w[0] = fill(16'h1000) + w[0];
      ex(fill(16'h1000), w[0]);
      notes.push_back({2'd1, 16'h1000, fill(16'h1000) + w[0]});
      fin(1'b0);
      issue(mf, ka, 0, 0, 16'h1000, 0, 0, 0);
      a = fill(16'h1202) >> 8;
      ex(a, w[0]);
      a = a + w[0];
      notes.push_back({2'd1, 16'h1203, 8'h00, a[7:0]});
      fin(1'b0);
      issue(mf, ka, 1, 0, 16'h1203, 0, 0, 0);
      ex(w[3], w[0]);
      fin(1'b0);
      issue(md, ka, 0, 0, 0, 4'h3, 4'h7, 0);
      w[7] = w[3] + w[0];
      count(7);
      // mapped addresses move between registers without touching memory
      fin(1'b0);
      issue(mf, kl, 0, 0, 16'h0006, 0, 4'h5, 0);
      w[5] = w[3];
      count(5);
      fin(1'b0);
      issue(mf, ks, 0, 0, 16'h000a, 4'h7, 0, 0);
      w[5] = w[7];
      count(5);
      lit = 16'($random(seed));
      ex(lit, w[2]);
      fin(1'b0);
      issue(mm, ka, 0, 0, 0, 4'h2, 4'h9, lit);
      w[9] = lit + w[2];
      count(9);
      fin(1'b0);
      issue(mf, kl, 0, 0, 16'h2000, 0, 4'h4, 0);
      // an indirect result goes back to the word the pointer names
      ex(16'h2000, w[0]);
      notes.push_back({2'd1, fill(16'h2000), 16'h2000 + w[0]});
      fin(1'b0);
      issue(mi, ka, 0, 0, 0, 4'h4, 0, 0);
      repeat (2) @(posedge mclk);
      if (notes.size() != 0) miscompares++;
      end_sim();
   end
endmodule : tb_data_operand_addressing
`default_nettype wire
